// *** shared/pvc_pkg.sv ***
/*
 * Constants shared by the PLL VCO-calibration and counter-sync control block.
 * Assumes a single 10 MHz system clock and an 8-bit register port.
 */
package pvc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 10;
   localparam int          DATA_W        = 8;
   localparam logic [9:0]  REG_CAL_CTRL  = 10'h018;
   localparam logic [9:0]  REG_SYNC_DLY  = 10'h019;
   localparam logic [9:0]  REG_UPDATE    = 10'h232;
   localparam logic [9:0]  REG_CAL_STAT  = 10'h0F0;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int          CAL_NOW_BIT   = 0;
   localparam int          CAL_DIV_LSB   = 1;
   localparam int          UPDATE_BIT    = 0;
   localparam int          STAT_BUSY_BIT = 0;
   localparam int          STAT_VALID_BIT = 1;
   localparam int          SYNC_MODE_LSB = 6;
   localparam int          REF_DLY_LSB   = 3;
   localparam int          FB_DLY_LSB    = 0;
   localparam logic [7:0]  CAL_CTRL_RST  = 8'h06;
   localparam logic [7:0]  SYNC_DLY_RST  = 8'h00;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 100;
   localparam int          CAL_TICKS_DEF = 64;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SM_NONE  = 2'b00,
      SM_ASYNC = 2'b01,
      SM_SYNC  = 2'b10,
      SM_NONE2 = 2'b11
   } pvc_sync_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b10
   } pvc_cal_state_t;

   // Division ratio of the calibration clock for each divider code.
   function automatic logic [4:0] cal_div_ratio(input logic [1:0] code);
      case (code)
         2'b00:   cal_div_ratio = 5'h02;
         2'b01:   cal_div_ratio = 5'h04;
         2'b10:   cal_div_ratio = 5'h08;
         default: cal_div_ratio = 5'h10;
      endcase
   endfunction

endpackage

// *** logic/pvc_cal_div.sv ***
/*
 * Calibration clock divider: counts reference clock edges and gives one tick
 * per divided period.
 * Assumes ref_edge is a one-cycle pulse already in the CLK domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pvc_cal_div
   import pvc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic       run,
   input  wire logic       ref_edge,
   input  wire logic [1:0] div_code,
   // Divided tick
   output logic            tick
);

   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       tick_nxt;
   logic [4:0] ratio;
   logic       wrap;

   assign ratio    = cal_div_ratio(div_code); // RQ1 RQ8
   assign wrap     = ref_edge && (cnt_r == ratio - 5'h01);
   assign cnt_nxt  = !run ? 5'h00 : wrap ? 5'h00 : ref_edge ? cnt_r + 5'h01 : cnt_r;
   assign tick_nxt = run && wrap;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [5:0] edges_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         edges_r <= 6'h00;
      end else if (!run || tick) begin
         edges_r <= {5'h00, ref_edge && run};
      end else if (ref_edge) begin
         edges_r <= edges_r + 6'h01;
      end
   end

   chk_div_ratio: assert property (@(posedge clk) disable iff (!rst_n) // RQ1 RQ8
      (tick && $past(run) && $stable(div_code)) |-> (edges_r == {1'b0, ratio}))
      else $error("calibration tick does not match divider ratio");

   cover_div16: cover property (@(posedge clk) disable iff (!rst_n) tick && div_code == 2'b11);

endmodule
`default_nettype wire

// *** logic/pvc_ctrl.sv ***
/*
 * PLL VCO-calibration and counter-sync control with buffered registers.
 * Assumes software on a plain register port and asynchronous REF_CLK and
 * SYNC_N pins; REF_CLK must run well below half the CLK rate.
 */
//
// Contract
// [RQ1] Default divider code divides reference by sixteen.
// [RQ2] Calibration starts only on active-copy rising edge.
// [RQ3] Software: reference present, clear, update, set, update.
// [RQ4] Clearing active calibrate bit discards calibration result.
// [RQ5] Software keeps holdover enables zero during calibration.
// [RQ6] Sync mode: none, async reset, sync reset, none.
// [RQ7] Reference and feedback path delays, reset zero.
// [RQ8] Other divider codes divide by two, four, eight.
// [RQ9] Writes buffered; update copies, then self-clears.
`timescale 1ns/1ps
`default_nettype none
module pvc_ctrl
   import pvc_pkg::*;
#(
   parameter int CAL_TICKS = CAL_TICKS_DEF
)(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              ARST_N,
   // Register port
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic [DATA_W-1:0]      RDATA,
   // Pins
   input  wire logic              REF_CLK,
   input  wire logic              SYNC_N,
   // Calibration
   output logic                   CAL_BUSY,
   output logic                   CAL_VALID,
   output logic                   CAL_TICK,
   // Counter control and path delays
   output logic                   CTR_ARST,
   output logic                   CTR_SRST,
   output logic [2:0]             REF_DLY,
   output logic [2:0]             FB_DLY
);

   // ---------------------------------------------------------------
   // Reset release and pin synchronisers
   // ---------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n;
   logic ref_s1_r;
   logic ref_s2_r;
   logic ref_s3_r;
   logic sync_s1_r;
   logic sync_s2_r;
   logic sync_s3_r;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ref_s1_r  <= 1'b0;
         ref_s2_r  <= 1'b0;
         ref_s3_r  <= 1'b0;
         sync_s1_r <= 1'b1;
         sync_s2_r <= 1'b1;
         sync_s3_r <= 1'b1;
      end else begin
         ref_s1_r  <= REF_CLK;
         ref_s2_r  <= ref_s1_r;
         ref_s3_r  <= ref_s2_r;
         sync_s1_r <= SYNC_N;
         sync_s2_r <= sync_s1_r;
         sync_s3_r <= sync_s2_r;
      end
   end

   wire ref_edge  = ref_s2_r && !ref_s3_r;
   wire sync_low  = !sync_s2_r;
   wire sync_fall = sync_s3_r && !sync_s2_r;

   // ---------------------------------------------------------------
   // Register file: buffer copy, active copy, update command
   // ---------------------------------------------------------------
   logic [7:0] cal_buf_r;
   logic [7:0] sync_buf_r;
   logic [7:0] cal_act_r;
   logic [7:0] sync_act_r;
   logic       upd_r;
   logic       upd_nxt;

   wire wr_cal  = WR && (ADDR == REG_CAL_CTRL);
   wire wr_sync = WR && (ADDR == REG_SYNC_DLY);
   wire wr_upd  = WR && (ADDR == REG_UPDATE) && WDATA[UPDATE_BIT];

   assign upd_nxt = wr_upd; // RQ9

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cal_buf_r  <= CAL_CTRL_RST;
         sync_buf_r <= SYNC_DLY_RST;
      end else begin
         if (wr_cal) begin
            cal_buf_r <= WDATA;
         end
         if (wr_sync) begin
            sync_buf_r <= WDATA;
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cal_act_r  <= CAL_CTRL_RST;
         sync_act_r <= SYNC_DLY_RST;
         upd_r      <= 1'b0;
      end else begin
         upd_r <= upd_nxt;
         if (upd_r) begin
            cal_act_r  <= cal_buf_r;   // RQ9
            sync_act_r <= sync_buf_r;  // RQ9
         end
      end
   end

   wire            cal_now_act = cal_act_r[CAL_NOW_BIT];
   wire            cal_now_buf = cal_buf_r[CAL_NOW_BIT];
   wire [1:0]      cal_div     = cal_act_r[CAL_DIV_LSB +: 2];
   pvc_sync_mode_t sync_mode;
   assign sync_mode = pvc_sync_mode_t'(sync_act_r[SYNC_MODE_LSB +: 2]);

   // ---------------------------------------------------------------
   // Calibration sequencer
   // ---------------------------------------------------------------
   pvc_cal_state_t st_r;
   pvc_cal_state_t st_nxt;
   logic [15:0]    ticks_r;
   logic [15:0]    ticks_nxt;
   logic           tick;

   wire cal_start   = upd_r && cal_now_buf && !cal_now_act; // RQ2
   wire cal_discard = upd_r && !cal_now_buf;                // RQ4
   wire cal_last    = tick && (ticks_r == 16'(CAL_TICKS - 1));

   pvc_cal_div u_cal_div (
      .clk      (CLK),
      .rst_n    (rst_n),
      .run      (st_r == ST_RUN),
      .ref_edge (ref_edge),
      .div_code (cal_div),
      .tick     (tick)
   );

   always_comb begin
      st_nxt    = st_r;
      ticks_nxt = ticks_r;
      case (st_r)
         ST_IDLE: begin
            ticks_nxt = 16'h0000;
            if (cal_start) begin
               st_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (tick) begin
               ticks_nxt = ticks_r + 16'h0001;
            end
            if (cal_last) begin
               st_nxt = ST_DONE;
            end
         end
         ST_DONE: begin
            ticks_nxt = 16'h0000;
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
      if (cal_discard) begin
         st_nxt    = ST_IDLE; // RQ4
         ticks_nxt = 16'h0000;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= ST_IDLE;
         ticks_r   <= 16'h0000;
         CAL_BUSY  <= 1'b0;
         CAL_VALID <= 1'b0;
         CAL_TICK  <= 1'b0;
      end else begin
         st_r      <= st_nxt;
         ticks_r   <= ticks_nxt;
         CAL_BUSY  <= (st_nxt == ST_RUN);
         CAL_VALID <= (st_nxt == ST_DONE); // RQ4
         CAL_TICK  <= tick;
      end
   end

   // ---------------------------------------------------------------
   // Counter reset on the alignment pin and path delays
   // ---------------------------------------------------------------
   wire arst_nxt = (sync_mode == SM_ASYNC) && sync_low;  // RQ6
   wire srst_nxt = (sync_mode == SM_SYNC) && sync_fall;  // RQ6

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CTR_ARST <= 1'b0;
         CTR_SRST <= 1'b0;
         REF_DLY  <= SYNC_DLY_RST[REF_DLY_LSB +: 3];
         FB_DLY   <= SYNC_DLY_RST[FB_DLY_LSB +: 3];
      end else begin
         CTR_ARST <= arst_nxt;
         CTR_SRST <= srst_nxt;
         REF_DLY  <= upd_r ? sync_buf_r[REF_DLY_LSB +: 3] : REF_DLY; // RQ7
         FB_DLY   <= upd_r ? sync_buf_r[FB_DLY_LSB +: 3] : FB_DLY;   // RQ7
      end
   end

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [7:0] rd_mux;

   always_comb begin
      case (ADDR)
         REG_CAL_CTRL: rd_mux = cal_buf_r;
         REG_SYNC_DLY: rd_mux = sync_buf_r;
         REG_UPDATE:   rd_mux = {7'h00, upd_r};
         REG_CAL_STAT: rd_mux = {6'h00, CAL_VALID, CAL_BUSY};
         default:      rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= RD ? rd_mux : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_update_copies: assert property (@(posedge CLK) disable iff (!rst_n) // RQ9
      upd_r |=> (cal_act_r == $past(cal_buf_r)) && (sync_act_r == $past(sync_buf_r)) && (upd_r == $past(wr_upd)))
      else $error("update did not copy buffer or did not self-clear");

   chk_act_hold: assert property (@(posedge CLK) disable iff (!rst_n) // RQ9
      !upd_r |=> $stable(cal_act_r) && $stable(sync_act_r))
      else $error("active copy changed without update");

   chk_start_edge: assert property (@(posedge CLK) disable iff (!rst_n) // RQ2
      $rose(st_r == ST_RUN) |-> $rose(cal_now_act))
      else $error("calibration started without active rising edge");

   chk_discard_cal: assert property (@(posedge CLK) disable iff (!rst_n) // RQ4
      $fell(cal_now_act) |-> (st_r == ST_IDLE) ##1 (!CAL_VALID && !CAL_BUSY))
      else $error("calibration result kept after clear");

   chk_cal_length: assert property (@(posedge CLK) disable iff (!rst_n) // RQ1
      $rose(st_r == ST_DONE) |-> $past(ticks_r) == 16'(CAL_TICKS - 1))
      else $error("calibration ended after wrong tick count");

   chk_async_mode: assert property (@(posedge CLK) disable iff (!rst_n) // RQ6
      (sync_mode == SM_ASYNC && sync_low) |=> CTR_ARST)
      else $error("async counter reset missing");

   chk_idle_modes: assert property (@(posedge CLK) disable iff (!rst_n) // RQ6
      (sync_mode == SM_NONE || sync_mode == SM_NONE2) |=> (!CTR_ARST && !CTR_SRST))
      else $error("counter reset in no-action mode");

   chk_sync_pulse: assert property (@(posedge CLK) disable iff (!rst_n) // RQ6
      (sync_mode == SM_SYNC && sync_fall) |=> CTR_SRST ##1 !CTR_SRST)
      else $error("sync counter reset longer than one cycle");

   chk_path_delay: assert property (@(posedge CLK) disable iff (!rst_n) // RQ7
      upd_r |=> (REF_DLY == $past(sync_buf_r[5:3])) && (FB_DLY == $past(sync_buf_r[2:0])))
      else $error("path delay outputs not loaded on update");

   cover_cal_done: cover property (@(posedge CLK) disable iff (!rst_n) $rose(CAL_VALID));
   cover_async_rst: cover property (@(posedge CLK) disable iff (!rst_n) $rose(CTR_ARST));
   cover_sync_rst: cover property (@(posedge CLK) disable iff (!rst_n) CTR_SRST);
   cover_abort: cover property (@(posedge CLK) disable iff (!rst_n) CAL_BUSY && cal_discard);

endmodule
`default_nettype wire

// *** testbench/pvc_ctrl_tb_top.sv ***
/*
 * Self-checking testbench for the PLL calibration and counter-sync control.
 * Assumes pvc_ctrl is driven on its plain register port at a 10 MHz CLK and
 * that REF_CLK is a free-running reference made here at one eighth of CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module pvc_ctrl_tb_top;
   import pvc_pkg::*;

   // ---------------------------------------------------------------
   // Signals and counters
   // ---------------------------------------------------------------
   localparam int     CAL_T = 4;
   logic              CLK = 1'b0;
   logic              ARST_N = 1'b0;
   logic [ADDR_W-1:0] ADDR = '0;
   logic [DATA_W-1:0] WDATA = '0;
   logic              WR = 1'b0;
   logic              RD = 1'b0;
   logic [DATA_W-1:0] RDATA;
   logic              REF_CLK = 1'b0;
   logic              SYNC_N = 1'b1;
   logic              CAL_BUSY;
   logic              CAL_VALID;
   logic              CAL_TICK;
   logic              CTR_ARST;
   logic              CTR_SRST;
   logic [2:0]        REF_DLY;
   logic [2:0]        FB_DLY;
   logic [2:0]        ref_ph = 3'h0;
   int                ref_rises = 0;
   int                cyc = 0;
   int                num_errors = 0;
   int                checked = 0;

   pvc_ctrl #(.CAL_TICKS(CAL_T)) u_dut (
      .CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .REF_CLK(REF_CLK), .SYNC_N(SYNC_N), .CAL_BUSY(CAL_BUSY),
      .CAL_VALID(CAL_VALID), .CAL_TICK(CAL_TICK), .CTR_ARST(CTR_ARST),
      .CTR_SRST(CTR_SRST), .REF_DLY(REF_DLY), .FB_DLY(FB_DLY));

   always #50 CLK = ~CLK;

   // Reference clock of eight CLK periods; rising edges are counted here.
   always @(posedge CLK) begin
      ref_ph <= ref_ph + 3'h1;
      REF_CLK <= ref_ph[2];
      if (ref_ph == 3'h4) begin
         ref_rises <= ref_rises + 1;
      end
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp, input string what);
      checked++;
      if (got != exp) begin
         num_errors++;
         $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input string what);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp, what);
   endtask

   task automatic upd();
      wr(REG_UPDATE, 8'h01);
   endtask

   // Waits a bounded time for busy (sel 0) or valid (sel 1) to reach lvl.
   task automatic wait_flag(input bit sel, input logic lvl, input int lim, input string what);
      int i;
      for (i = 0; i < lim && (sel ? CAL_VALID : CAL_BUSY) !== lvl; i++) begin
         @(posedge CLK);
         #1;
      end
      chk({7'h00, (sel ? CAL_VALID : CAL_BUSY)}, {7'h00, lvl}, what);
   endtask

   task automatic cal_run(input logic [1:0] code);
      int ticks;
      int last;
      int i;
      ticks = 0;
      last = 0;
      wr(REG_CAL_CTRL, {5'h00, code, 1'b0});
      upd();
      wr(REG_CAL_CTRL, {5'h00, code, 1'b1});
      upd();
      wait_flag(1'b0, 1'b1, 10, "busy start");
      for (i = 0; i < 4000 && CAL_VALID !== 1'b1; i++) begin
         @(posedge CLK);
         #1;
         if (CAL_TICK === 1'b1) begin
            if (ticks > 0) chk_n(ref_rises - last, 2 << code, "ref edges per tick");
            last = ref_rises;
            ticks++;
         end
      end
      chk_n(ticks, CAL_T, "tick count");
      chk({7'h00, CAL_BUSY}, 8'h00, "busy after run");
      rd_chk(REG_CAL_STAT, 8'h02, "status valid");
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int m;
      int i;
      int na;
      int ns;
      repeat (3) @(posedge CLK);
      ARST_N <= 1'b1;
      repeat (4) @(posedge CLK);
      rd_chk(REG_CAL_CTRL, 8'h06, "cal ctrl reset");
      rd_chk(REG_SYNC_DLY, 8'h00, "sync reset");
      @(posedge CLK);
      #1;
      chk(RDATA, 8'h00, "rdata one cycle");
      rd_chk(REG_UPDATE, 8'h00, "update reset");
      rd_chk(10'h3FF, 8'h00, "unmapped read");
      chk({2'b00, REF_DLY, FB_DLY}, 8'h00, "delay reset");
      wr(REG_SYNC_DLY, 8'h2B);
      wr(10'h3FF, 8'hFF);
      rd_chk(REG_SYNC_DLY, 8'h2B, "buffer copy");
      chk({2'b00, REF_DLY, FB_DLY}, 8'h00, "no update yet");
      upd();
      repeat (3) @(posedge CLK);
      #1;
      chk({5'h00, REF_DLY}, 8'h05, "ref delay");
      chk({5'h00, FB_DLY}, 8'h03, "fb delay");
      rd_chk(REG_UPDATE, 8'h00, "update cleared");
      wr(REG_CAL_CTRL, 8'h07);
      repeat (20) @(posedge CLK);
      #1;
      chk({7'h00, CAL_BUSY}, 8'h00, "no start without update");
      for (m = 0; m < 4; m++) begin
         cal_run(m[1:0]);
      end
      upd();
      repeat (20) @(posedge CLK);
      #1;
      chk({6'h00, CAL_BUSY, CAL_VALID}, 8'h01, "no restart when set");
      wr(REG_CAL_CTRL, 8'h06);
      upd();
      wait_flag(1'b1, 1'b0, 5, "result discarded");
      wr(REG_CAL_CTRL, 8'h07);
      upd();
      wait_flag(1'b0, 1'b1, 10, "restart");
      repeat (20) @(posedge CLK);
      wr(REG_CAL_CTRL, 8'h06);
      upd();
      wait_flag(1'b0, 1'b0, 5, "run aborted");
      chk({7'h00, CAL_VALID}, 8'h00, "no result after abort");
      for (m = 0; m < 4; m++) begin
         wr(REG_SYNC_DLY, {m[1:0], 6'h00});
         upd();
         repeat (4) @(posedge CLK);
         na = 0;
         ns = 0;
         SYNC_N <= 1'b0;
         for (i = 0; i < 20; i++) begin
            @(posedge CLK);
            if (i == 9) SYNC_N <= 1'b1;
            #1;
            na += (CTR_ARST === 1'b1);
            ns += (CTR_SRST === 1'b1);
         end
         chk_n(na, (m == 1) ? 10 : 0, "async reset cycles");
         chk_n(ns, (m == 2) ? 1 : 0, "sync reset pulses");
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
